// *** verilog/tcds_pkg.sv ***
// Purpose: shared constants and types for the two-channel delay sequencer
// Assumes: 10 MHz clock, 10 ms time-base tick
// Notes:   interval figures are given in seconds or ms and converted to ticks of the time base
`default_nettype none
package tcds_pkg;

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam logic [31:0] TICKS_PER_S = 32'(1000 / TICK_MS);
	// initialisation after supply, least time so round up
	localparam int INIT_MS = 250;
	localparam logic [31:0] INIT_TICKS = 32'((INIT_MS + TICK_MS - 1) / TICK_MS);
	// fixed pre-start durations
	localparam int PRE_ON_S = 10;
	localparam int PRE_GAP_S = 30;
	localparam logic [31:0] PRE_ON_TICKS = 32'(PRE_ON_S) * TICKS_PER_S;
	localparam logic [31:0] PRE_GAP_TICKS = 32'(PRE_GAP_S) * TICKS_PER_S;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int SET_W = 8;
	localparam int RNG_W = 3;
	localparam int MODE_W = 3;
	localparam int CNT_W = 32;
	localparam int BOOT_CYC = 3;
	localparam int BLINK_BIT = 5;

	// ----------------------------------------------------------------
	// full-scale of each range, seconds
	// ----------------------------------------------------------------
	localparam logic [31:0] T1_FS_S [8] = '{32'h1, 32'hA, 32'h64, 32'h3C,
		32'h258, 32'h1770, 32'hE10, 32'h8CA0};
	localparam logic [31:0] T2_FS_S [8] = '{32'hA, 32'h64, 32'h3C, 32'h258,
		32'h1770, 32'hE10, 32'h8CA0, 32'h11940};

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [MODE_W-1:0] {
		MODE_ON_DELAY = 3'h0,
		MODE_PULSE1 = 3'h1,
		MODE_INTER1 = 3'h2,
		MODE_PRESTART = 3'h3,
		MODE_PULSE2 = 3'h4,
		MODE_INTER2 = 3'h5,
		MODE_OFF_DELAY = 3'h6,
		MODE_RESERVED = 3'h7
	} tcds_mode_t;

	typedef enum logic [2:0] {
		PH_DARK = 3'h0,
		PH_INIT = 3'h1,
		PH_A = 3'h2,
		PH_B = 3'h3,
		PH_C = 3'h4,
		PH_DONE = 3'h5
	} tcds_phase_t;

	// setting scaled into its range; full knob gives just under full scale
	function automatic logic [31:0] interval_ticks(input logic [SET_W-1:0] set,
		input logic [RNG_W-1:0] rng, input logic second);
		logic [31:0] fs;
		logic [SET_W+31:0] prod;
		fs = second ? T2_FS_S[rng] * TICKS_PER_S : T1_FS_S[rng] * TICKS_PER_S;
		prod = {{SET_W{1'b0}}, fs} * {32'h0000_0000, set};
		return prod[SET_W+31:SET_W];
	endfunction

endpackage
`default_nettype wire

// *** verilog/tcds_timer.sv ***
// Purpose: per-channel down counter on the shared time-base tick
// Assumes: load wins over counting in the same cycle
// Notes:   done stays high from expiry until the next load
`timescale 1ns/1ns
`default_nettype none
module tcds_timer #(
	parameter int CNT_W = tcds_pkg::CNT_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// control
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic [CNT_W-1:0] load_val_i,
	// status
	output logic done_o
);

	typedef struct packed {
		logic run;
		logic [CNT_W-1:0] cnt;
	} tcds_tmr_t;

	tcds_tmr_t q;
	tcds_tmr_t d;

	always_comb begin
		d = q;
		if (load_i) begin
			d.run = 1'b1;
			d.cnt = load_val_i;
		end else if (q.run && tick_i && (q.cnt != '0)) begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done_o = q.run && (q.cnt == '0);

endmodule
`default_nettype wire

// *** verilog/tcds_sequencer.sv ***
// Purpose: two-channel programmable delay sequencer with seven algorithms
// Assumes: knobs and range switches are static while a duration is loaded
// Notes:   one 10 ms time base feeds both channel timers
`timescale 1ns/1ns
`default_nettype none

module tcds_sequencer #(
	parameter int TICK_CYCLES = tcds_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// algorithm selector
	input wire logic [tcds_pkg::MODE_W-1:0] algo_select_i,
	// supply triggers
	input wire logic ch1_supply_input_i,
	input wire logic ch2_supply_input_i,
	// channel 1 settings
	input wire logic [tcds_pkg::SET_W-1:0] ch1_first_interval_setting_i,
	input wire logic [tcds_pkg::SET_W-1:0] ch1_second_interval_setting_i,
	input wire logic [tcds_pkg::RNG_W-1:0] range_select_ch1_i,
	// channel 2 settings
	input wire logic [tcds_pkg::SET_W-1:0] ch2_first_interval_setting_i,
	input wire logic [tcds_pkg::SET_W-1:0] ch2_second_interval_setting_i,
	input wire logic [tcds_pkg::RNG_W-1:0] range_select_ch2_i,
	// channel 1 load and indicator
	output logic ch1_no_closed_o,
	output logic ch1_nc_closed_o,
	output logic ch1_led_green_o,
	output logic ch1_led_red_o,
	// channel 2 load and indicator
	output logic ch2_no_closed_o,
	output logic ch2_nc_closed_o,
	output logic ch2_led_green_o,
	output logic ch2_led_red_o
);

	localparam int DIV_W = $clog2(TICK_CYCLES);
	localparam int CW = tcds_pkg::CNT_W;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] nc;
		logic [1:0] no;
		logic [1:0] grn;
		logic [1:0] red;
		logic [tcds_pkg::MODE_W-1:0] m1;
		logic [tcds_pkg::MODE_W-1:0] m2;
		logic [tcds_pkg::MODE_W-1:0] m3;
		logic [1:0] boot;
		logic booted;
		tcds_pkg::tcds_mode_t mode;
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic [1:0] pres;
		logic [1:0] pv;
		logic [DIV_W-1:0] div;
		logic tick;
		logic [tcds_pkg::BLINK_BIT:0] blk;
		tcds_pkg::tcds_phase_t [1:0] ph;
		logic od_on;
	} tcds_state_t;

	localparam int SW = $bits(tcds_state_t);
	// normally-closed pairs rest closed
	localparam tcds_state_t ST_RST = tcds_state_t'({2'h3, {(SW-2){1'b0}}});

	tcds_state_t q;
	tcds_state_t n;
	logic [1:0] ld;
	logic [CW-1:0] lv [2];
	logic [1:0] done;
	logic [CW-1:0] t1 [2];
	logic [CW-1:0] t2 [2];
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] on;

	// ----------------------------------------------------------------
	// channel timers
	// ----------------------------------------------------------------
	// per-channel counters
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_tmr
			tcds_timer #(
				.CNT_W(CW)
			) u_tmr (
				.clk_i(clk_i),
				.nrst_i(nrst_i),
				.tick_i(q.tick),
				.load_i(ld[g]),
				.load_val_i(lv[g]),
				.done_o(done[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		n = q;
		ld = '0;
		lv[0] = '0;
		lv[1] = '0;
		on = '0;
		t1[0] = tcds_pkg::interval_ticks(ch1_first_interval_setting_i, range_select_ch1_i, 1'b0);
		t2[0] = tcds_pkg::interval_ticks(ch1_second_interval_setting_i, range_select_ch1_i, 1'b1);
		t1[1] = tcds_pkg::interval_ticks(ch2_first_interval_setting_i, range_select_ch2_i, 1'b0);
		t2[1] = tcds_pkg::interval_ticks(ch2_second_interval_setting_i, range_select_ch2_i, 1'b1);

		// pin synchronisers; a supply level counts once stages two and three agree
		n.m1 = algo_select_i;
		n.m2 = q.m1;
		n.m3 = q.m2;
		n.s1 = {ch2_supply_input_i, ch1_supply_input_i};
		n.s2 = q.s1;
		n.s3 = q.s2;
		for (int i = 0; i < 2; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				n.pres[i] = q.s3[i];
			end
		end
		n.pv = q.pres;
		rise = q.pres & ~q.pv;
		fall = ~q.pres & q.pv;

		n.tick = 1'b0;
		if (q.div == DIV_W'(TICK_CYCLES - 1)) begin
			n.div = '0;
			n.tick = 1'b1;
		end else begin
			n.div = q.div + 1'b1;
		end
		if (q.tick) begin
			n.blk = q.blk + 1'b1;
		end

		if (!q.booted) begin
			// selector captured once, after the synchroniser has filled
			if (q.boot == 2'(tcds_pkg::BOOT_CYC)) begin
				n.booted = 1'b1;
				n.mode = tcds_pkg::tcds_mode_t'(q.m3);
			end else begin
				n.boot = q.boot + 1'b1;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (rise[i] && !(q.mode == tcds_pkg::MODE_OFF_DELAY && i == 0 && !q.pres[1])) begin
					n.ph[i] = tcds_pkg::PH_INIT;
					ld[i] = 1'b1;
					lv[i] = tcds_pkg::INIT_TICKS;
				end else if (fall[i]) begin
					n.ph[i] = tcds_pkg::PH_DARK;
					if (q.mode == tcds_pkg::MODE_OFF_DELAY && i == 0 && q.pres[1]) begin
						n.ph[1] = tcds_pkg::PH_A;
						ld[1] = 1'b1;
						lv[1] = t1[1] + t2[1];
					end
					if (q.mode == tcds_pkg::MODE_OFF_DELAY && i == 1) begin
						n.ph[0] = tcds_pkg::PH_DARK;
						n.od_on = 1'b0;
					end
				end else if (done[i] && q.ph[i] != tcds_pkg::PH_DARK
					&& q.ph[i] != tcds_pkg::PH_DONE) begin
					// durations are read only when loaded
					ld[i] = 1'b1;
					case (q.mode)
						tcds_pkg::MODE_ON_DELAY, tcds_pkg::MODE_PULSE2: begin
							if (q.ph[i] == tcds_pkg::PH_INIT) begin
								n.ph[i] = tcds_pkg::PH_A;
								lv[i] = t1[i] + t2[i];
							end else begin
								n.ph[i] = tcds_pkg::PH_DONE;
							end
						end
						tcds_pkg::MODE_PULSE1: begin
							if (q.ph[i] == tcds_pkg::PH_INIT) begin
								n.ph[i] = tcds_pkg::PH_A;
								lv[i] = t2[i];
							end else if (q.ph[i] == tcds_pkg::PH_A) begin
								n.ph[i] = tcds_pkg::PH_B;
								lv[i] = t1[i];
							end else begin
								n.ph[i] = tcds_pkg::PH_DONE;
							end
						end
						tcds_pkg::MODE_INTER1: begin
							if (q.ph[i] == tcds_pkg::PH_A && t2[i] != '0) begin
								n.ph[i] = tcds_pkg::PH_B;
								lv[i] = t2[i];
							end else begin
								n.ph[i] = tcds_pkg::PH_A;
								lv[i] = t1[i];
							end
						end
						tcds_pkg::MODE_INTER2: begin
							if (q.ph[i] != tcds_pkg::PH_A && t1[i] != '0) begin
								n.ph[i] = tcds_pkg::PH_A;
								lv[i] = t1[i];
							end else begin
								n.ph[i] = tcds_pkg::PH_B;
								lv[i] = t2[i];
							end
						end
						tcds_pkg::MODE_PRESTART: begin
							if (i == 1 || q.ph[i] == tcds_pkg::PH_C) begin
								n.ph[i] = tcds_pkg::PH_DONE;
							end else if (q.ph[i] == tcds_pkg::PH_INIT) begin
								n.ph[i] = tcds_pkg::PH_A;
								lv[i] = tcds_pkg::PRE_ON_TICKS;
							end else if (q.ph[i] == tcds_pkg::PH_A) begin
								n.ph[i] = tcds_pkg::PH_B;
								lv[i] = tcds_pkg::PRE_GAP_TICKS;
							end else begin
								n.ph[i] = tcds_pkg::PH_C;
								lv[i] = tcds_pkg::PRE_GAP_TICKS;
							end
						end
						tcds_pkg::MODE_OFF_DELAY: begin
							if (i == 0 && q.ph[i] == tcds_pkg::PH_INIT) begin
								n.ph[i] = tcds_pkg::PH_A;
								lv[i] = t1[0] + t2[0];
							end else begin
								n.ph[i] = tcds_pkg::PH_DONE;
								if (i == 0 && q.ph[i] == tcds_pkg::PH_A) begin
									n.od_on = 1'b1;
								end
								if (i == 1 && q.ph[i] == tcds_pkg::PH_A) begin
									n.od_on = 1'b0;
								end
							end
						end
						default: begin
							n.ph[i] = tcds_pkg::PH_DONE;
						end
					endcase
				end
			end
		end

		// ------------------------------------------------------------
		// contacts and indicators
		// ------------------------------------------------------------
		for (int i = 0; i < 2; i++) begin
			case (q.mode)
				tcds_pkg::MODE_ON_DELAY: begin
					on[i] = n.ph[i] == tcds_pkg::PH_DONE;
				end
				tcds_pkg::MODE_PULSE1, tcds_pkg::MODE_INTER1: begin
					on[i] = n.ph[i] == tcds_pkg::PH_B;
				end
				tcds_pkg::MODE_PULSE2, tcds_pkg::MODE_INTER2: begin
					// ON in phase A: the t1+t2 sum in pulse2, the first interval in inter2
					on[i] = n.ph[i] == tcds_pkg::PH_A;
				end
				tcds_pkg::MODE_PRESTART: begin
					if (i == 0) begin
						on[i] = n.ph[i] == tcds_pkg::PH_A || n.ph[i] == tcds_pkg::PH_C;
					end else begin
						// channel 2 closes after the sequence
						// never while channel 1 is closed
						on[i] = n.ph[1] == tcds_pkg::PH_DONE && n.ph[0] == tcds_pkg::PH_DONE
							&& !on[0];
					end
				end
				tcds_pkg::MODE_OFF_DELAY: begin
					on[i] = i == 1 && n.od_on && n.ph[1] != tcds_pkg::PH_DARK;
				end
				default: begin
					on[i] = 1'b0;
				end
			endcase
			n.no[i] = on[i];
			n.nc[i] = !on[i];
			if (n.ph[i] == tcds_pkg::PH_DARK) begin
				n.grn[i] = 1'b0;
				n.red[i] = 1'b0;
			end else if (q.mode == tcds_pkg::MODE_RESERVED
				&& n.ph[i] == tcds_pkg::PH_DONE) begin
				// unused selection only blinks, contacts stay open
				n.grn[i] = q.blk[tcds_pkg::BLINK_BIT];
				n.red[i] = !q.blk[tcds_pkg::BLINK_BIT];
			end else begin
				n.grn[i] = !on[i];
				n.red[i] = on[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q <= ST_RST;
		end else begin
			q <= n;
		end
	end

	assign ch1_no_closed_o = q.no[0];
	assign ch1_nc_closed_o = q.nc[0];
	assign ch1_led_green_o = q.grn[0];
	assign ch1_led_red_o = q.red[0];
	assign ch2_no_closed_o = q.no[1];
	assign ch2_nc_closed_o = q.nc[1];
	assign ch2_led_green_o = q.grn[1];
	assign ch2_led_red_o = q.red[1];

endmodule
`default_nettype wire

// *** test/tcds_sequencer_monitor.sv ***
// Purpose: port checks for the delay sequencer
// Assumes: algorithm pins steady for a few clocks after reset
// Notes:   mode copy taken early; supply ignored before that anyway
`timescale 1ns/1ns
`default_nettype none
module tcds_sequencer_monitor #(
	parameter int TICK_CYCLES = 100000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// inputs watched
	input wire logic [tcds_pkg::MODE_W-1:0] algo_select_i,
	input wire logic ch1_supply_input_i,
	// outputs watched
	input wire logic ch1_no_closed_o,
	input wire logic ch1_nc_closed_o,
	input wire logic ch1_led_green_o,
	input wire logic ch1_led_red_o,
	input wire logic ch2_no_closed_o,
	input wire logic ch2_nc_closed_o,
	input wire logic ch2_led_red_o
);
	localparam int INIT_LIM = (int'(tcds_pkg::INIT_TICKS) - 1) * TICK_CYCLES;
	logic [2:0] boot_q;
	logic [2:0] mode_q;
	logic [31:0] up_q;
	logic ok;
	assign ok = boot_q == 3'h7;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			boot_q <= 3'h0;
			mode_q <= 3'h0;
			up_q <= 32'h0;
		end else begin
			if (!ok)
				boot_q <= boot_q + 3'h1;
			if (boot_q == 3'h2)
				mode_q <= algo_select_i;
			up_q <= ch1_supply_input_i ? up_q + 32'h1 : 32'h0;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_pair_ch1: assert property (ch1_nc_closed_o == !ch1_no_closed_o)
		else $error("ch1 contact pairs not opposite");
	a_pair_ch2: assert property (ch2_nc_closed_o == !ch2_no_closed_o)
		else $error("ch2 contact pairs not opposite");
	a_red_ch1: assert property (ch1_no_closed_o |-> ch1_led_red_o && !ch1_led_green_o)
		else $error("ch1 on without red");
	a_red_ch2: assert property (ch2_no_closed_o |-> ch2_led_red_o)
		else $error("ch2 on without red");
	a_dark_ch1: assert property (!ch1_supply_input_i [*6] |=>
		!ch1_no_closed_o && !ch1_led_green_o && !ch1_led_red_o)
		else $error("ch1 lit without supply");
	a_init_hold: assert property (ch1_supply_input_i && up_q < INIT_LIM |-> !ch1_no_closed_o)
		else $error("ch1 switched during initialisation");
	a_pre_lock: assert property (ok && mode_q == tcds_pkg::MODE_PRESTART |->
		!(ch1_no_closed_o && ch2_no_closed_o))
		else $error("both channels on in pre-start");
	a_od_open: assert property (ok && mode_q == tcds_pkg::MODE_OFF_DELAY |-> !ch1_no_closed_o)
		else $error("ch1 closed in off-delay");
	a_od_latch: assert property (ok && mode_q == tcds_pkg::MODE_ON_DELAY &&
		$fell(ch1_no_closed_o) |-> !$past(ch1_supply_input_i, 2))
		else $error("on-delay output fell with supply present");
	c_ch1_on: cover property ($rose(ch1_no_closed_o));
	c_pre_end: cover property (mode_q == tcds_pkg::MODE_PRESTART && $rose(ch2_no_closed_o));
	c_od_on: cover property (mode_q == tcds_pkg::MODE_OFF_DELAY && $rose(ch2_no_closed_o));
endmodule
`default_nettype wire

// *** test/tcds_supply_model.sv ***
// Purpose: supply source feeding both channel inputs
// Assumes: requests come from the bench
// Notes:   no bounce modelled; inputs are filtered by the design
`timescale 1ns/1ns
`default_nettype none
module tcds_supply_model (
	// requests
	input wire logic ch1_req_i,
	input wire logic ch2_req_i,
	input wire logic offdly_i,
	// supply pins
	output logic ch1_supply_o,
	output logic ch2_supply_o
);
	// ch2 main power
	// in off-delay, trigger only reaches ch1 while main feed is up
	assign ch1_supply_o = ch1_req_i && (ch2_req_i || !offdly_i);
	assign ch2_supply_o = ch2_req_i;
endmodule
`default_nettype wire

// *** test/tcds_sequencer_tb.sv ***
// Purpose: self-checking bench for the delay sequencer
// Assumes: tick shortened to 5 clocks
// Notes:   edge times counted from the supply change, then from the previous edge
`timescale 1ns/1ns
`default_nettype none
module tcds_sequencer_tb;
	localparam int T = 5;
	logic clk_i = 1'h0;
	logic nrst_i = 1'h0;
	logic [2:0] algo = 3'h0;
	logic r1 = 1'h0, r2 = 1'h0, od = 1'h0, s1, s2;
	logic [7:0] a1 = 8'h80, b1 = 8'h20, a2 = 8'h08, b2 = 8'h02;
	logic [2:0] g1 = 3'h0, g2 = 3'h1;
	wire [1:0] no, nc, gr, rd;
	logic led_was;
	int failures = 0;
	int compares = 0;
	// mode, ch1 knobs, ch1 edge ticks, ch2 edge ticks; 0 ends the list
	int rows[8][9] = '{'{0, 8'h80, 8'h20, 200, 0, 0, 134, 0, 0},
		'{0, 8'h00, 8'h00, 25, 0, 0, 134, 0, 0}, '{1, 8'h80, 8'h20, 150, 50, 0, 103, 31, 0},
		'{2, 8'h80, 8'h20, 75, 125, 50, 56, 78, 31}, '{2, 8'h80, 8'h00, 0, 0, 0, 56, 78, 31},
		'{4, 8'h80, 8'h20, 25, 175, 0, 25, 109, 0}, '{5, 8'h80, 8'h20, 25, 50, 125, 25, 31, 78},
		'{5, 8'h00, 8'h20, 0, 0, 0, 25, 31, 78}};
	always #50 clk_i = ~clk_i;
	tcds_supply_model i_sup(.ch1_req_i(r1), .ch2_req_i(r2), .offdly_i(od),
		.ch1_supply_o(s1), .ch2_supply_o(s2));
	tcds_sequencer #(.TICK_CYCLES(T)) i_dut(.clk_i(clk_i), .nrst_i(nrst_i),
		.algo_select_i(algo), .ch1_supply_input_i(s1), .ch2_supply_input_i(s2),
		.ch1_first_interval_setting_i(a1), .ch1_second_interval_setting_i(b1),
		.range_select_ch1_i(g1), .ch2_first_interval_setting_i(a2),
		.ch2_second_interval_setting_i(b2), .range_select_ch2_i(g2),
		.ch1_no_closed_o(no[0]), .ch1_nc_closed_o(nc[0]), .ch1_led_green_o(gr[0]),
		.ch1_led_red_o(rd[0]), .ch2_no_closed_o(no[1]), .ch2_nc_closed_o(nc[1]),
		.ch2_led_green_o(gr[1]), .ch2_led_red_o(rd[1]));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic boot(input logic [2:0] m);
		nrst_i = 1'h0;
		algo = m;
		cyc(3);
		check("reset", {no, nc, gr, rd}, 8'h30);
		nrst_i = 1'h1;
		cyc(8);
	endtask
	// wait for the next contact change; e ticks expected, 0 means none
	task automatic watch(input int c, input int e);
		int n;
		int lim;
		logic v;
		v = no[c];
		lim = (e == 0) ? 120 * T : e * T + 10;
		n = 0;
		while (no[c] === v && n < lim) begin
			cyc(1);
			n++;
		end
		check("edge time", (e == 0) ? n >= lim : n >= e * T - T - 8 && n < lim, 1'h1);
		check("leds", {rd[c], gr[c], nc[c]}, {no[c], !no[c], !no[c]});
	endtask
	task automatic seq(input int c, input int i, input int o);
		for (int k = 0; k < 3; k++) begin
			watch(c, rows[i][o + k]);
			if (rows[i][o + k] == 0)
				break;
		end
	endtask
	initial begin
		#8000000;
		failures++;
		end_of_test();
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		for (int i = 0; i < 8; i++) begin
			a1 = 8'(rows[i][1]);
			b1 = 8'(rows[i][2]);
			boot(3'(rows[i][0]));
			// ch2 starts later to show independent timing
			fork
				begin r1 = 1'h1; seq(0, i, 3); end
				begin cyc(7); r2 = 1'h1; seq(1, i, 6); end
			join
			r1 = 1'h0;
			r2 = 1'h0;
			cyc(8);
			check("dark", {no, gr, rd}, 6'h0);
			$display("row %0d done", i);
		end
		// settings far off: fixed durations must still hold
		a1 = 8'hFF;
		b1 = 8'hFF;
		g1 = 3'h7;
		boot(3'h3);
		r1 = 1'h1;
		r2 = 1'h1;
		watch(0, 25);
		check("pre ch2 wait", {no[1], gr[1]}, 2'h1);
		watch(0, 1000);
		watch(0, 3000);
		watch(0, 3000);
		cyc(3);
		check("pre end", {no[1], rd[1], no[0], gr[0]}, 4'hD);
		watch(0, 0);
		$display("pre-start done");
		a1 = 8'h80;
		b1 = 8'h20;
		g1 = 3'h0;
		od = 1'h1;
		r1 = 1'h0;
		r2 = 1'h0;
		boot(3'h6);
		r2 = 1'h1;
		algo = 3'h0;
		cyc(40 * T);
		check("od standby", {no, gr, rd}, 6'h08);
		r1 = 1'h1;
		watch(1, 200);
		check("od on", {gr[0], rd[1]}, 2'h3);
		r1 = 1'h0;
		cyc(8);
		check("od ch1 dark", gr[0], 1'h0);
		watch(1, 109);
		$display("off-delay done");
		// knob change mid-delay only counts from the next supply cycle
		od = 1'h0;
		r1 = 1'h0;
		r2 = 1'h0;
		boot(3'h0);
		r1 = 1'h1;
		cyc(50 * T);
		a1 = 8'h00;
		b1 = 8'h00;
		watch(0, 150);
		r1 = 1'h0;
		cyc(8);
		r1 = 1'h1;
		watch(0, 25);
		r1 = 1'h0;
		$display("setting change done");
		// unused selection: contacts stay open, colours alternate
		boot(3'h7);
		r1 = 1'h1;
		cyc(30 * T);
		led_was = gr[0];
		check("reserved leds", {no[0], nc[0], gr[0] ^ rd[0]}, 3'h3);
		cyc(32 * T);
		check("reserved blink", {no[0], nc[0], gr[0], rd[0]}, {2'h1, !led_was, led_was});
		r1 = 1'h0;
		$display("reserved done");
		end_of_test();
	end
endmodule
bind tcds_sequencer tcds_sequencer_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon(
	.clk_i(clk_i), .nrst_i(nrst_i), .algo_select_i(algo_select_i),
	.ch1_supply_input_i(ch1_supply_input_i), .ch1_no_closed_o(ch1_no_closed_o),
	.ch1_nc_closed_o(ch1_nc_closed_o), .ch1_led_green_o(ch1_led_green_o),
	.ch1_led_red_o(ch1_led_red_o), .ch2_no_closed_o(ch2_no_closed_o),
	.ch2_nc_closed_o(ch2_nc_closed_o), .ch2_led_red_o(ch2_led_red_o));
`default_nettype wire
